/* rtl/aitc_ctrl.sv */
// converter control: injection, power-off, calibration, registers
// assumes an ahb-lite master and the core on the bus clock
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - injection runs inside a running mode, then resumes
// - injection needs enable and wait-read mode
// - channel field never written, only result
// - injected channel not latched, mux follows field
// - request set by software or capture event
// - capture event sets request regardless of enable, except during injection
// - capture triggers ignored during injection; request held
// - software start aborts any injection, begun from idle or mid-run
// - hardware trigger uses bank as it stands
// - current conversion completes before injected one
// - injected result to alt register, aux flag
// - full temp buffer suspends next conversion
// - power-off deferred until busy clears
// - start wakes core; settling is software's job
// - power-off plus start: convert, then off
// - power-off during calibration stops it until reset
// - top four control bits select timing
// - fast code phase table
// - middle code phase table
// - slow code phase table
// - total is sample, compare and transfer
// - result read copies buffer and resumes
// - bank bit selects input port
module aitc_ctrl
  import aitc_pkg::*;
#(
  parameter int CAL_CYCLES = AITC_CAL_CYCLES
)
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // capture/compare unit
  input  wire logic        capture_ch_last,
  // analog core and multiplexer
  input  wire logic [9:0]  core_result,
  output logic             analog_power_on,
  output logic             bank_select,
  output logic [3:0]       mux_channel,
  output logic             sample_phase,
  output logic             compare_phase,
  // status
  output logic             busy_flag,
  output logic             end_irq_flag,
  output logic             aux_irq_flag
);

  typedef struct packed {
    aitc_state_t st;
    logic [15:0] cal_cnt;
    logic        cal_ok;
    logic [3:0]  adch;
    logic [3:0]  ch;
    logic [1:0]  mode;
    logic        start;
    logic        wrm;
    logic        inj_en;
    logic        inj_req;
    logic [1:0]  stc;
    logic [1:0]  ctc;
    logic        bank;
    logic        poff;
    logic        inj;
    logic        inj_idle;
    logic [9:0]  res;
    logic [3:0]  res_ch;
    logic        res_unread;
    logic [3:0]  alt_ch;
    logic [9:0]  alt_res;
    logic [9:0]  tmp;
    logic [3:0]  tmp_ch;
    logic        tmp_full;
    logic        eoc;
    logic        aux;
    logic        a_sel;
    logic        a_wr;
    logic [7:0]  a_off;
    logic [31:0] rdata;
  } aitc_ctrl_t;

  aitc_ctrl_t r_reg;
  aitc_ctrl_t r_next;

  logic tstart;
  logic tdone;
  logic start_rise;
  logic launch;
  logic more;
  logic pend;
  logic rd_req;

  // ***********************************************
  // phase timer
  // ***********************************************
  aitc_phase_timer u_timer (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .start            (tstart),
    .conv_time_code   (r_next.ctc),
    .sample_time_code (r_next.stc),
    .sample_phase     (sample_phase),
    .compare_phase    (compare_phase),
    .done             (tdone)
  );

  // ***********************************************
  // next state
  // ***********************************************
  always_comb
  begin
    r_next     = r_reg;
    tstart     = 1'b0;
    start_rise = 1'b0;
    launch     = 1'b0;
    more       = 1'b0;
    rd_req     = hsel && hready && htrans[1] && !hwrite;

    // address phase, zero wait states
    r_next.a_sel = hsel && hready && htrans[1];
    r_next.a_wr  = hwrite;
    r_next.a_off = haddr[7:0];
    if (rd_req)
    begin
      r_next.rdata = 32'h0000_0000;
      unique case (haddr[7:0])
        AITC_OFF_CTRL:
          r_next.rdata[15:0] = {r_reg.ctc, r_reg.stc, r_reg.inj_req, r_reg.inj_en,
                                r_reg.wrm, (r_reg.st != AITC_IDLE), r_reg.start, 1'b0,
                                r_reg.mode, r_reg.adch};
        AITC_OFF_RES:
          r_next.rdata[15:0] = {r_reg.res_ch, 2'b00, r_reg.res};
        AITC_OFF_ALT:
          r_next.rdata[15:0] = {r_reg.alt_ch, 2'b00, r_reg.alt_res};
        AITC_OFF_MISC:
          r_next.rdata[AITC_B_POFF:0] = {r_reg.poff, r_reg.bank};
        AITC_OFF_FLAGS:
          r_next.rdata[AITC_B_CALOK:0] = {r_reg.cal_ok, r_reg.aux, r_reg.eoc};
        default:
          r_next.rdata = 32'h0000_0000;
      endcase
      if (haddr[7:0] == AITC_OFF_RES)
      begin
        r_next.res_unread = 1'b0;
        if (r_reg.tmp_full)
        begin
          r_next.res        = r_reg.tmp;
          r_next.res_ch     = r_reg.tmp_ch;
          r_next.res_unread = 1'b1;
          r_next.eoc        = 1'b1;
          r_next.tmp_full   = 1'b0;
          if (r_reg.st == AITC_HOLD)
          begin
            r_next.st = AITC_RUN;
            tstart    = 1'b1;
          end
        end
      end
    end

    // data phase writes
    if (r_reg.a_sel && r_reg.a_wr)
    begin
      unique case (r_reg.a_off)
        AITC_OFF_CTRL:
        begin
          r_next.adch    = hwdata[AITC_B_CH_HI:AITC_B_CH_LO];
          r_next.mode    = hwdata[AITC_B_MD_HI:AITC_B_MD_LO];
          start_rise     = hwdata[AITC_B_START] && !r_reg.start;
          r_next.start   = hwdata[AITC_B_START];
          r_next.wrm     = hwdata[AITC_B_WRM];
          r_next.inj_en  = hwdata[AITC_B_INJEN];
          r_next.inj_req = hwdata[AITC_B_INJRQ];
          r_next.stc     = hwdata[AITC_B_STC_HI:AITC_B_STC_LO];
          r_next.ctc     = hwdata[AITC_B_CTC_HI:AITC_B_CTC_LO];
        end
        AITC_OFF_ALT:
          r_next.alt_ch = hwdata[AITC_B_RCH_HI:AITC_B_RCH_LO];
        AITC_OFF_MISC:
        begin
          r_next.bank = hwdata[AITC_B_BANK];
          r_next.poff = hwdata[AITC_B_POFF];
        end
        AITC_OFF_FLAGS:
        begin
          if (hwdata[AITC_B_EOC])
          begin
            r_next.eoc = 1'b0;
          end
          if (hwdata[AITC_B_AUX])
          begin
            r_next.aux = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // capture events set the request even with injection disabled;
    // an event beside a software clear still wins
    if (capture_ch_last && !(r_reg.inj && r_reg.st != AITC_IDLE))
    begin
      r_next.inj_req = 1'b1;
    end
    pend = r_next.inj_req && r_next.inj_en && r_next.wrm;

    // ***********************************************
    // sequencer
    // ***********************************************
    unique case (r_reg.st)
      AITC_CAL:
      begin
        r_next.start = 1'b0;
        if (r_next.poff)
        begin
          // never resumed; cal_ok low until reset
          r_next.st = AITC_IDLE;
        end
        else if (r_reg.cal_cnt == 16'(CAL_CYCLES - 1))
        begin
          // junk left in result
          r_next.st         = AITC_IDLE;
          r_next.cal_ok     = 1'b1;
          r_next.res_unread = 1'b1;
          r_next.eoc        = 1'b1;
          r_next.aux        = 1'b1;
        end
        else
        begin
          r_next.cal_cnt = 16'(r_reg.cal_cnt + 16'h0001);
        end
      end
      AITC_IDLE:
      begin
        if (start_rise)
        begin
          r_next.ch = r_next.adch;
          launch    = 1'b1;
        end
        else if (pend)
        begin
          r_next.inj      = 1'b1;
          r_next.inj_idle = 1'b1;
          launch          = 1'b1;
        end
      end
      default:
      begin
        if (start_rise)
        begin
          // a fresh start aborts any run
          r_next.inj      = 1'b0;
          r_next.inj_idle = 1'b0;
          r_next.ch       = r_next.adch;
          launch          = 1'b1;
        end
        else if (r_reg.st == AITC_RUN && tdone)
        begin
          if (r_reg.inj)
          begin
            r_next.alt_res  = core_result;
            r_next.aux      = 1'b1;
            r_next.inj_req  = 1'b0;
            r_next.inj      = 1'b0;
            r_next.inj_idle = 1'b0;
            more            = !r_reg.inj_idle;
          end
          else
          begin
            if (r_reg.wrm && r_next.res_unread)
            begin
              r_next.tmp      = core_result;
              r_next.tmp_ch   = r_reg.ch;
              r_next.tmp_full = 1'b1;
            end
            else
            begin
              if (r_next.res_unread)
              begin
                r_next.aux = 1'b1;
              end
              r_next.res        = core_result;
              r_next.res_ch     = r_reg.ch;
              r_next.res_unread = 1'b1;
              r_next.eoc        = 1'b1;
            end
            if (r_reg.mode[AITC_MD_SCAN] && r_reg.ch != 4'h0)
            begin
              r_next.ch = 4'(r_reg.ch - 4'h1);
              more      = 1'b1;
            end
            else if (r_reg.mode[AITC_MD_CONT] && r_next.start)
            begin
              r_next.ch = r_next.adch;
              more      = 1'b1;
            end
            else
            begin
              r_next.start = 1'b0;
            end
          end
          if (pend && !r_reg.inj)
          begin
            r_next.inj = 1'b1;
            launch     = 1'b1;
          end
          else if (more)
          begin
            launch = 1'b1;
          end
          else
          begin
            r_next.st = AITC_IDLE;
          end
        end
      end
    endcase

    if (launch)
    begin
      if (r_next.tmp_full)
      begin
        r_next.st = AITC_HOLD;
      end
      else
      begin
        r_next.st = AITC_RUN;
        tstart    = 1'b1;
      end
    end
  end

  // ***********************************************
  // state register
  // ***********************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ***********************************************
  // outputs
  // ***********************************************
  assign hrdata          = r_reg.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign busy_flag       = (r_reg.st != AITC_IDLE);
  // power-off bites only once idle
  assign analog_power_on = !r_reg.poff || (r_reg.st != AITC_IDLE);
  assign bank_select     = r_reg.bank;
  // live alt field: an alt write while sampling an injected channel moves the mux
  assign mux_channel     = r_reg.inj ? r_reg.alt_ch : r_reg.ch;
  assign end_irq_flag    = r_reg.eoc;
  assign aux_irq_flag    = r_reg.aux;

endmodule

`default_nettype wire

/* rtl/aitc_phase_timer.sv */
// sample, compare and transfer phases of one conversion
// assumes a one-cycle start pulse; a new start restarts at once
`timescale 1ns/10ps
`default_nettype none

module aitc_phase_timer
  import aitc_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       start,
  input  wire logic [1:0] conv_time_code,
  input  wire logic [1:0] sample_time_code,
  // phase outputs
  output logic            sample_phase,
  output logic            compare_phase,
  output logic            done
);

  typedef struct packed {
    aitc_phase_t ph;
    logic [10:0] cnt;
    logic [1:0]  ctc;
    logic [1:0]  stc;
    logic        done;
  } aitc_tmr_t;

  aitc_tmr_t r_reg;
  aitc_tmr_t r_next;

  // phase cycles from half-clock units
  function automatic logic [10:0] cyc(input logic [10:0] half_clock_unit);
    cyc = 11'((half_clock_unit / AITC_TCL_PER_CLK) - 11'h001);
  endfunction

  always_comb
  begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    if (start)
    begin
      // codes caught at start; later writes wait
      r_next.ph  = AITC_PH_SMP;
      r_next.ctc = conv_time_code;
      r_next.stc = sample_time_code;
      r_next.cnt = cyc(aitc_smp_tcl(conv_time_code, sample_time_code));
    end
    else if (r_reg.ph != AITC_PH_IDLE)
    begin
      if (r_reg.cnt != 11'h000)
      begin
        r_next.cnt = 11'(r_reg.cnt - 11'h001);
      end
      else
      begin
        unique case (r_reg.ph)
          AITC_PH_SMP:
          begin
            r_next.ph  = AITC_PH_CMP;
            r_next.cnt = cyc(aitc_cmp_tcl(r_reg.ctc, r_reg.stc));
          end
          AITC_PH_CMP:
          begin
            r_next.ph  = AITC_PH_XFR;
            r_next.cnt = cyc(aitc_xfr_tcl(r_reg.ctc, r_reg.stc));
          end
          default:
          begin
            r_next.ph   = AITC_PH_IDLE;
            r_next.done = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r_reg <= '{ph: AITC_PH_IDLE, cnt: 11'h000, ctc: 2'b00, stc: 2'b00, done: 1'b0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  assign sample_phase  = (r_reg.ph == AITC_PH_SMP);
  assign compare_phase = (r_reg.ph == AITC_PH_CMP);
  assign done          = r_reg.done;

endmodule

`default_nettype wire

/* rtl/aitc_pkg.sv */
// constants, types and timing tables of the converter control
// assumes a 32-bit ahb-lite bus; one clock is two half-clock units
package aitc_pkg;

  // ***********************************************
  // register map (byte offsets, one word each)
  // ***********************************************
  localparam logic [7:0] AITC_OFF_CTRL  = 8'h00;
  localparam logic [7:0] AITC_OFF_RES   = 8'h04;
  localparam logic [7:0] AITC_OFF_ALT   = 8'h08;
  localparam logic [7:0] AITC_OFF_MISC  = 8'h0c;
  localparam logic [7:0] AITC_OFF_FLAGS = 8'h10;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int AITC_B_CH_LO  = 0;
  localparam int AITC_B_CH_HI  = 3;
  localparam int AITC_B_MD_LO  = 4;
  localparam int AITC_B_MD_HI  = 5;
  localparam int AITC_B_START  = 7;
  localparam int AITC_B_BUSY   = 8;
  localparam int AITC_B_WRM    = 9;
  localparam int AITC_B_INJEN  = 10;
  localparam int AITC_B_INJRQ  = 11;
  localparam int AITC_B_STC_LO = 12;
  localparam int AITC_B_STC_HI = 13;
  localparam int AITC_B_CTC_LO = 14;
  localparam int AITC_B_CTC_HI = 15;
  localparam int AITC_B_RCH_LO = 12;
  localparam int AITC_B_RCH_HI = 15;
  localparam int AITC_B_BANK   = 0;
  localparam int AITC_B_POFF   = 1;
  localparam int AITC_B_EOC    = 0;
  localparam int AITC_B_AUX    = 1;
  localparam int AITC_B_CALOK  = 2;
  localparam int AITC_MD_CONT  = 0;
  localparam int AITC_MD_SCAN  = 1;

  // ***********************************************
  // timing
  // ***********************************************
  localparam int          AITC_CAL_CYCLES   = 40629;
  localparam logic [10:0] AITC_TCL_PER_CLK  = 11'h002;
  localparam logic [1:0]  AITC_CTC_SLOW     = 2'b10;
  localparam logic [1:0]  AITC_CTC_MID      = 2'b11;

  typedef enum logic [1:0] {
    AITC_CAL  = 2'b00,
    AITC_IDLE = 2'b01,
    AITC_RUN  = 2'b11,
    AITC_HOLD = 2'b10
  } aitc_state_t;

  typedef enum logic [1:0] {
    AITC_PH_IDLE = 2'b00,
    AITC_PH_SMP  = 2'b01,
    AITC_PH_CMP  = 2'b11,
    AITC_PH_XFR  = 2'b10
  } aitc_phase_t;

  // phase lengths in half-clock units; code 01 runs as 00
  function automatic logic [10:0] aitc_smp_tcl(input logic [1:0] ctc, input logic [1:0] stc);
    logic [10:0] base;
    base = (stc == 2'b00) ? 11'd120 : (stc == 2'b01) ? 11'd140 :
           (stc == 2'b10) ? 11'd200 : 11'd400;
    unique case (ctc)
      AITC_CTC_MID:  aitc_smp_tcl = (stc == 2'b11) ? 11'd800 : 11'(base << 1);
      AITC_CTC_SLOW: aitc_smp_tcl = (stc == 2'b11) ? 11'd1600 : 11'(base << 2);
      default:       aitc_smp_tcl = base;
    endcase
  endfunction

  function automatic logic [10:0] aitc_cmp_tcl(input logic [1:0] ctc, input logic [1:0] stc);
    logic [10:0] base;
    base = (stc == 2'b00) ? 11'd240 : 11'd280;
    unique case (ctc)
      AITC_CTC_MID:  aitc_cmp_tcl = 11'(base << 1);
      AITC_CTC_SLOW: aitc_cmp_tcl = 11'(base << 2);
      default:       aitc_cmp_tcl = base;
    endcase
  endfunction

  function automatic logic [10:0] aitc_xfr_tcl(input logic [1:0] ctc, input logic [1:0] stc);
    logic [10:0] t;
    unique case ({ctc, stc})
      4'b1100: t = 11'd52;
      4'b1101: t = 11'd28;
      4'b1110: t = 11'd100;
      4'b1111: t = 11'd52;
      4'b1000: t = 11'd100;
      4'b1001: t = 11'd52;
      4'b1010: t = 11'd196;
      4'b1011: t = 11'd164;
      4'b0001,
      4'b0101: t = 11'd16;
      4'b0010,
      4'b0110: t = 11'd52;
      4'b0011,
      4'b0111: t = 11'd44;
      default: t = 11'd28;
    endcase
    aitc_xfr_tcl = t;
  endfunction

endpackage

/* testbench/aitc_core_model.sv */
// behavioural mux and converter core
// assumes phase and channel come from the control block
`timescale 1ns/10ps
`default_nettype none

module aitc_core_model
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // controls from the block
  input wire logic        analog_power_on,
  input wire logic        bank_select,
  input wire logic [3:0]  mux_channel,
  input wire logic        sample_phase,
  // result
  output logic     [9:0]  core_result
);
  logic [9:0] held_reg;

  // tracks the mux while sampling
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      held_reg <= 10'h000;
    else if (sample_phase)
      held_reg <= {bank_select, mux_channel, 5'h15};
  end

  // unpowered core gives garbage
  assign core_result = analog_power_on ? held_reg : ~held_reg;
endmodule

`default_nettype wire

/* testbench/aitc_ctrl_tb.sv */
// self-checking bench of the converter control
// assumes the core model behind the mux
`timescale 1ns/10ps
`default_nettype none

module aitc_ctrl_tb;
  import aitc_pkg::*;
  localparam int CAL = 20;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, capture_ch_last;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [9:0]  core_result;
  logic [3:0]  mux_channel;
  logic        analog_power_on, bank_select, sample_phase, compare_phase;
  logic        busy_flag, end_irq_flag, aux_irq_flag;
  int          n_errors, compares, i;
  int          smp_base [4] = '{120, 140, 200, 400};
  int          mult     [4] = '{1, 2, 4, 1};
  logic [1:0]  ctcs     [4] = '{2'b00, 2'b11, 2'b10, 2'b01};
  int          xtra     [16] = '{28, 16, 52, 44, 28, 16, 52, 44,
                                 100, 52, 196, 164, 52, 28, 100, 52};

  assign hready = hreadyout;

  aitc_ctrl #(.CAL_CYCLES(CAL)) u_aitc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .capture_ch_last(capture_ch_last), .core_result(core_result),
    .analog_power_on(analog_power_on), .bank_select(bank_select), .mux_channel(mux_channel),
    .sample_phase(sample_phase), .compare_phase(compare_phase), .busy_flag(busy_flag),
    .end_irq_flag(end_irq_flag), .aux_irq_flag(aux_irq_flag));

  aitc_core_model u_aitc_core_model (.hclk(hclk), .hresetn(hresetn),
    .analog_power_on(analog_power_on), .bank_select(bank_select), .mux_channel(mux_channel),
    .sample_phase(sample_phase), .core_result(core_result));

  // ***********************************************
  // tasks
  // ***********************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic ahb_xfer(input logic wr, input logic [7:0] off, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h0, off}; htrans <= 2'b10; hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hsel <= 1'b0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic ahb_write(input logic [7:0] off, input logic [31:0] d);
    ahb_xfer(1'b1, off, d);
  endtask

  task automatic ahb_read(input logic [7:0] off);
    ahb_xfer(1'b0, off, 32'h0);
  endtask

  function automatic logic [31:0] ctrl_w(input logic [1:0] ctc, input logic [1:0] stc,
      input logic rq, input logic ie, input logic wr, input logic st,
      input logic [1:0] md, input logic [3:0] ch);
    return {16'h0, ctc, stc, rq, ie, wr, 1'b0, st, 1'b0, md, ch};
  endfunction

  function automatic logic [9:0] exp_res(input logic b, input logic [3:0] c);
    return {b, c, 5'h15};
  endfunction

  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  task automatic pulse_cap();
    @(posedge hclk); capture_ch_last <= 1'b1;
    @(posedge hclk); capture_ch_last <= 1'b0;
  endtask

  task automatic start_conv(input logic [31:0] w);
    ahb_write(AITC_OFF_CTRL, w & ~32'h80);
    ahb_write(AITC_OFF_CTRL, w | 32'h80);
    while (sample_phase !== 1'b1) @(posedge hclk);
  endtask

  // two half-clock units per cycle
  task automatic conv_one(input logic [1:0] ctc, input logic [1:0] stc, input logic [3:0] ch,
      input int s_exp, input int c_exp, input int x_exp);
    int ns = 0, nc = 0, nx = 0;
    ahb_write(AITC_OFF_FLAGS, 32'h3);
    start_conv(ctrl_w(ctc, stc, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, ch));
    while (sample_phase === 1'b1) begin ns++; @(posedge hclk); end
    while (compare_phase === 1'b1) begin nc++; @(posedge hclk); end
    while (end_irq_flag !== 1'b1) begin nx++; @(posedge hclk); end
    check(ns, s_exp / 2);
    check(nc, c_exp / 2);
    check(32'(nx >= x_exp / 2 && nx <= x_exp / 2 + 3), 32'd1);
    ahb_read(AITC_OFF_RES);
    check(rd[15:0], {ch, 2'b00, exp_res(1'b0, ch)});
  endtask

  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ***********************************************
  // clock, watchdog and tests
  // ***********************************************
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // tests need under 20000 cycles
  initial
  begin
    repeat (60000) @(posedge hclk);
    n_errors++;
    complete_run();
  end

  initial
  begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0; capture_ch_last = 1'b0; n_errors = 0; compares = 0;
    do_reset();
    for (i = 0; i < CAL + 10 && busy_flag !== 1'b0; i++) @(posedge hclk);
    ahb_read(AITC_OFF_FLAGS);
    check(rd[2:0], 3'b111);
    ahb_read(AITC_OFF_RES);
    ahb_read(8'h20);
    check(rd, 32'h0);
    for (int k = 0; k < 4; k++)
      for (int s = 0; s < 4; s++)
        conv_one(ctcs[k], 2'(s), 4'(s + k), smp_base[s] * mult[k],
                 (s == 0 ? 240 : 280) * mult[k], xtra[{ctcs[k], 2'(s)}]);
    // capture sets request when disabled
    ahb_write(AITC_OFF_FLAGS, 32'h3);
    ahb_write(AITC_OFF_ALT, {16'h0, 4'h5, 12'h0});
    pulse_cap();
    ahb_read(AITC_OFF_CTRL);
    check(rd[11], 1'b1);
    ahb_write(AITC_OFF_CTRL, ctrl_w(2'b00, 2'b00, 1'b0, 1'b0, 1'b1, 1'b0, 2'b00, 4'h0));
    ahb_write(AITC_OFF_CTRL, ctrl_w(2'b00, 2'b00, 1'b0, 1'b1, 1'b1, 1'b0, 2'b00, 4'h0));
    ahb_write(AITC_OFF_CTRL, ctrl_w(2'b00, 2'b00, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 4'h0));
    while (sample_phase !== 1'b1) @(posedge hclk);
    check(mux_channel, 4'h5);
    pulse_cap();
    while (aux_irq_flag !== 1'b1) @(posedge hclk);
    ahb_read(AITC_OFF_ALT);
    check(rd[15:0], {4'h5, 2'b00, exp_res(1'b0, 4'h5)});
    ahb_read(AITC_OFF_CTRL);
    check(rd[11], 1'b0);
    // hardware trigger takes bank as it stands
    ahb_write(AITC_OFF_MISC, 32'h1);
    ahb_write(AITC_OFF_FLAGS, 32'h3);
    pulse_cap();
    while (aux_irq_flag !== 1'b1) @(posedge hclk);
    ahb_read(AITC_OFF_ALT);
    check(rd[15:0], {4'h5, 2'b00, exp_res(1'b1, 4'h5)});
    ahb_write(AITC_OFF_MISC, 32'h0);
    // power-off waits for busy to drop
    start_conv(ctrl_w(2'b00, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 4'h1));
    ahb_write(AITC_OFF_MISC, 32'h2);
    ahb_read(AITC_OFF_MISC);
    check(rd[1:0], 2'b10);
    check(analog_power_on, 1'b1);
    while (busy_flag !== 1'b0) @(posedge hclk);
    @(posedge hclk);
    check(analog_power_on, 1'b0);
    start_conv(ctrl_w(2'b00, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 4'h1));
    check(analog_power_on, 1'b1);
    while (busy_flag !== 1'b0) @(posedge hclk);
    @(posedge hclk);
    check(analog_power_on, 1'b0);
    ahb_write(AITC_OFF_MISC, 32'h0);
    // wait-read: second result parks, suspends
    ahb_read(AITC_OFF_RES);
    ahb_write(AITC_OFF_FLAGS, 32'h3);
    start_conv(ctrl_w(2'b00, 2'b00, 1'b0, 1'b0, 1'b1, 1'b0, 2'b01, 4'h3));
    repeat (1000) @(posedge hclk);
    check({busy_flag, sample_phase, compare_phase}, 3'b100);
    ahb_write(AITC_OFF_FLAGS, 32'h3);
    ahb_read(AITC_OFF_RES);
    check(rd[15:12], 4'h3);
    for (i = 0; i < 10 && sample_phase !== 1'b1; i++) @(posedge hclk);
    check({sample_phase, end_irq_flag}, 2'b11);
    // reset mid-run; power-off ends calibration
    do_reset();
    ahb_write(AITC_OFF_MISC, 32'h2);
    ahb_write(AITC_OFF_MISC, 32'h0);
    repeat (2 * CAL) @(posedge hclk);
    ahb_read(AITC_OFF_FLAGS);
    check(rd[2], 1'b0);
    complete_run();
  end
endmodule

`default_nettype wire

/* testbench/aitc_monitor.sv */
// concurrent checks on the control block ports
// assumes a bind into aitc_ctrl
`timescale 1ns/10ps
`default_nettype none

module aitc_monitor
  import aitc_pkg::*;
#(
  parameter int CAL_CYCLES = AITC_CAL_CYCLES
)
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus answer
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // core and status
  input wire logic        analog_power_on,
  input wire logic        sample_phase,
  input wire logic        compare_phase,
  input wire logic        busy_flag
);
  // ***********************************************
  // properties
  // ***********************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // shortest phase is 8 cycles
  sequence s_smp_min; sample_phase [*8]; endsequence
  sequence s_cmp_min; compare_phase [*8]; endsequence

  property p_bus_okay; hreadyout && !hresp; endproperty
  property p_upper_zero; hrdata[31:16] == 16'h0000; endproperty
  property p_phase_excl; !(sample_phase && compare_phase); endproperty
  property p_phase_busy; (sample_phase || compare_phase) |-> busy_flag; endproperty
  property p_busy_power; busy_flag |-> analog_power_on; endproperty
  property p_start_smp; $rose(busy_flag) |-> ##[0:3] sample_phase; endproperty
  property p_smp_min; $rose(sample_phase) |-> s_smp_min; endproperty
  property p_cmp_after; $rose(compare_phase) |-> $past(sample_phase) ##0 s_cmp_min; endproperty
  property p_xfr_gap; $fell(compare_phase) |-> (!sample_phase) [*8]; endproperty

  a_bus_okay:   assert property (p_bus_okay)   else $error("bus not okay");
  a_upper_zero: assert property (p_upper_zero) else $error("upper data set");
  a_phase_excl: assert property (p_phase_excl) else $error("phase overlap");
  a_phase_busy: assert property (p_phase_busy) else $error("phase not busy");
  a_busy_power: assert property (p_busy_power) else $error("off while busy");
  a_start_smp:  assert property (p_start_smp)  else $error("no sample");
  a_smp_min:    assert property (p_smp_min)    else $error("sample short");
  a_cmp_after:  assert property (p_cmp_after)  else $error("compare order");
  a_xfr_gap:    assert property (p_xfr_gap)    else $error("no transfer gap");
endmodule

bind aitc_ctrl aitc_monitor #(.CAL_CYCLES(CAL_CYCLES)) u_aitc_monitor (
  .hclk            (hclk),
  .hresetn         (hresetn),
  .hrdata          (hrdata),
  .hreadyout       (hreadyout),
  .hresp           (hresp),
  .analog_power_on (analog_power_on),
  .sample_phase    (sample_phase),
  .compare_phase   (compare_phase),
  .busy_flag       (busy_flag)
);

`default_nettype wire
